// ==== pstf_pkg.sv ====
// Shared types, timing constants and parameter set decoding for the port filter
package pstf_pkg;

    // =====================================================================
    // Clock and timebase
    // =====================================================================
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int MS_PER_TICK = TICK_US / 1000;

    // =====================================================================
    // Filter times per parameter set
    // =====================================================================
    localparam int STABLE_OSSD_MS = 100;
    localparam int MONITOR_OSSD_MS = 2000;
    localparam int STABLE_CONTACT_MS = 500;
    localparam int MONITOR_CONTACT_MS = 10000;

    // Longest off-going test pulse of an electronic output
    localparam int TP_MAX_US = 1000;
    localparam int TP_MAX_CYCLES = TP_MAX_US * CLK_MHZ;

    localparam int CNT_W = 14;
    typedef logic [CNT_W-1:0] tick_cnt_t;

    localparam tick_cnt_t STABLE_OSSD_TICKS = tick_cnt_t'(STABLE_OSSD_MS / MS_PER_TICK);
    localparam tick_cnt_t MONITOR_OSSD_TICKS = tick_cnt_t'(MONITOR_OSSD_MS / MS_PER_TICK);
    localparam tick_cnt_t STABLE_CONTACT_TICKS = tick_cnt_t'(STABLE_CONTACT_MS / MS_PER_TICK);
    localparam tick_cnt_t MONITOR_CONTACT_TICKS = tick_cnt_t'(MONITOR_CONTACT_MS / MS_PER_TICK);

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic [1:0] {
        PSET_OSSD_1W = 2'h0,
        PSET_OSSD_2W = 2'h1,
        PSET_CONTACT_PAIR = 2'h2,
        PSET_DUAL_SINGLE = 2'h3
    } pset_e;

    typedef enum logic [3:0] {
        F_IDLE = 4'h1,
        F_WATCH = 4'h2,
        F_ON = 4'h4,
        F_FAULT = 4'h8
    } filt_state_e;

    typedef struct packed {
        tick_cnt_t stable;
        tick_cnt_t monitor;
    } timing_s;

    typedef struct packed {
        logic a;
        logic b;
    } chan_pair_s;

    // =====================================================================
    // Parameter set decoding
    // =====================================================================
    function automatic logic pset_electronic(input pset_e t);
        return (t == PSET_OSSD_1W) || (t == PSET_OSSD_2W);
    endfunction : pset_electronic

    function automatic timing_s pset_timing(input pset_e t);
        timing_s r;
        if (pset_electronic(t))
        begin
            r.stable = STABLE_OSSD_TICKS;
            r.monitor = MONITOR_OSSD_TICKS;
        end
        else
        begin
            r.stable = STABLE_CONTACT_TICKS;
            r.monitor = MONITOR_CONTACT_TICKS;
        end
        return r;
    endfunction : pset_timing

endpackage : pstf_pkg

// ==== pstf_tick_gen.sv ====
// Fixed timebase tick for the filter counters
`timescale 1ns/1ps
module pstf_tick_gen #(
    parameter int DIV = pstf_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Tick
    output logic o_tick
);
    localparam int W = $clog2(DIV);

    logic [W-1:0] cnt_reg;
    logic tick_reg;

    // =====================================================================
    // Divider
    // =====================================================================
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else if (cnt_reg == W'(DIV - 1))
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + W'(1);
            tick_reg <= 1'b0;
        end
    end

    assign o_tick = tick_reg;

endmodule : pstf_tick_gen

// ==== pstf_stable_filter.sv ====
// Stable-time and monitoring-time filter for one channel or one channel pair
`timescale 1ns/1ps
module pstf_stable_filter (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Control
    input wire logic i_restart,
    input wire logic i_tick,
    input wire logic i_two_ch,
    input wire pstf_pkg::timing_s i_timing,
    input wire logic i_force_fault,
    // Inputs
    input wire pstf_pkg::chan_pair_s i_on,
    // Result
    output logic o_enable,
    output logic o_fault
);
    pstf_pkg::filt_state_e state_reg;
    pstf_pkg::filt_state_e state_next;
    pstf_pkg::tick_cnt_t stab_reg;
    pstf_pkg::tick_cnt_t mon_reg;
    pstf_pkg::chan_pair_s prev_reg;
    logic all_on;
    logic any_on;
    logic held;
    logic qualified;
    logic expired;

    assign all_on = i_two_ch ? (i_on.a & i_on.b) : i_on.a;
    assign any_on = i_two_ch ? (i_on.a | i_on.b) : i_on.a;
    // A lone channel must not be restarted by its unused neighbour bit
    assign held = all_on && (i_two_ch ? (i_on == prev_reg) : (i_on.a == prev_reg.a));
    assign qualified = held && (stab_reg >= i_timing.stable);
    assign expired = i_tick && (mon_reg >= i_timing.monitor - pstf_pkg::tick_cnt_t'(1));

    // =====================================================================
    // State
    // =====================================================================
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            pstf_pkg::F_IDLE:
            begin
                if (i_force_fault)
                    state_next = pstf_pkg::F_FAULT;
                else if (any_on)
                    state_next = pstf_pkg::F_WATCH;
            end
            pstf_pkg::F_WATCH:
            begin
                if (i_force_fault)
                    state_next = pstf_pkg::F_FAULT;
                else if (qualified)
                    state_next = pstf_pkg::F_ON;
                else if (expired)
                    state_next = pstf_pkg::F_FAULT;
                else if (i_two_ch && !any_on)
                    state_next = pstf_pkg::F_IDLE;
            end
            pstf_pkg::F_ON:
            begin
                if (i_force_fault)
                    state_next = pstf_pkg::F_FAULT;
                else if (!all_on)
                    state_next = pstf_pkg::F_IDLE;
            end
            pstf_pkg::F_FAULT:
            begin
                // Fault holds until every input is off again
                if (!any_on && !i_force_fault)
                    state_next = pstf_pkg::F_IDLE;
            end
            default:
                state_next = pstf_pkg::F_FAULT;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || i_restart)
            state_reg <= pstf_pkg::F_IDLE;
        else
            state_reg <= state_next;
    end

    // =====================================================================
    // Stable-time counter: any change of a channel in use restarts it
    // =====================================================================
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || i_restart || state_reg != pstf_pkg::F_WATCH || !held)
            stab_reg <= '0;
        else if (i_tick && stab_reg < i_timing.stable)
            stab_reg <= stab_reg + pstf_pkg::tick_cnt_t'(1);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            prev_reg <= '0;
        else
            prev_reg <= i_on;
    end

    // =====================================================================
    // Monitoring-time counter
    // =====================================================================
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || i_restart || state_reg != pstf_pkg::F_WATCH)
            mon_reg <= '0;
        else if (i_tick)
            mon_reg <= mon_reg + pstf_pkg::tick_cnt_t'(1);
    end

    assign o_enable = (state_reg == pstf_pkg::F_ON);
    assign o_fault = (state_reg == pstf_pkg::F_FAULT);

endmodule : pstf_stable_filter

// ==== port_stable_time_filter.sv ====
// Per-port input qualification: parameter sets, test pulse masking, cross-fault, filters
`timescale 1ns/1ps
module port_stable_time_filter #(
    parameter int NUM_PORTS = 8,
    parameter int TICK_DIV = pstf_pkg::TICK_CYCLES,
    parameter int TP_MAX = pstf_pkg::TP_MAX_CYCLES
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // Port configuration
    input wire logic [NUM_PORTS-1:0][1:0] I_PORT_SET,
    // Safety inputs
    input wire logic [NUM_PORTS-1:0] I_CH_A,
    input wire logic [NUM_PORTS-1:0] I_CH_B,
    // Present level of the device's own test pulse outputs
    input wire logic [NUM_PORTS-1:0] I_TP_OUT_A,
    input wire logic [NUM_PORTS-1:0] I_TP_OUT_B,
    // Qualified results
    output logic [NUM_PORTS-1:0] O_SAFE_ON,
    output logic [NUM_PORTS-1:0] O_SAFE_ON_B,
    output logic [NUM_PORTS-1:0] O_PORT_FAULT,
    // Diagnostics and wiring
    output logic [NUM_PORTS-1:0] O_CROSS_FAULT,
    output logic [NUM_PORTS-1:0] O_TP_SEEN,
    output logic [NUM_PORTS-1:0] O_XF_ACTIVE,
    output logic [NUM_PORTS-1:0] O_TWO_WIRE
);
    localparam int TPW = $clog2(TP_MAX + 1);

    logic tick;

    // =====================================================================
    // Timebase
    // =====================================================================
    pstf_tick_gen #(
        .DIV(TICK_DIV)
    ) u_tick (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .o_tick(tick)
    );

    // =====================================================================
    // Per-port logic
    // =====================================================================
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        pstf_pkg::pset_e set_reg;
        pstf_pkg::pset_e set_in;
        pstf_pkg::timing_s timing;
        pstf_pkg::chan_pair_s raw;
        pstf_pkg::chan_pair_s filt;
        pstf_pkg::chan_pair_s pair_on;
        pstf_pkg::chan_pair_s single_b_on;
        logic [1:0][TPW-1:0] low_cnt_reg;
        logic [1:0] was_on_reg;
        logic restart;
        logic electronic;
        logic two_ch;
        logic is_dual;
        logic xf_now;
        logic xf_reg;
        logic seen_reg;
        logic en_a;
        logic en_b;
        logic flt_a;
        logic flt_b;

        assign set_in = pstf_pkg::pset_e'(I_PORT_SET[p]);
        assign restart = (set_in != set_reg);
        assign electronic = pstf_pkg::pset_electronic(set_reg);
        assign is_dual = (set_reg == pstf_pkg::PSET_DUAL_SINGLE);
        assign two_ch = !is_dual;
        assign timing = pstf_pkg::pset_timing(set_reg);
        assign raw = '{a: I_CH_A[p], b: I_CH_B[p]};

        // A set change drops both filters back to idle before the new times apply
        always_ff @(posedge I_CLK)
        begin
            if (!I_RSTN)
                set_reg <= pstf_pkg::PSET_CONTACT_PAIR;
            else
                set_reg <= set_in;
        end

        // =================================================================
        // Off-going test pulse masking for electronic outputs
        // =================================================================
        // Costs up to one pulse length of extra delay on a real switch-off
        for (genvar c = 0; c < 2; c++)
        begin : g_ch
            logic ch_raw;

            assign ch_raw = (c == 0) ? raw.a : raw.b;

            always_ff @(posedge I_CLK)
            begin
                if (!I_RSTN || ch_raw)
                    low_cnt_reg[c] <= (ch_raw && I_RSTN) ? '0 : TPW'(TP_MAX);
                else if (low_cnt_reg[c] < TPW'(TP_MAX))
                    low_cnt_reg[c] <= low_cnt_reg[c] + TPW'(1);
            end

            always_ff @(posedge I_CLK)
            begin
                if (!I_RSTN)
                    was_on_reg[c] <= 1'b0;
                else
                    was_on_reg[c] <= ch_raw;
            end
        end

        assign filt.a = raw.a || (electronic && low_cnt_reg[0] < TPW'(TP_MAX));
        assign filt.b = raw.b || (electronic && low_cnt_reg[1] < TPW'(TP_MAX));

        // Sticky: a short low that came back high before the limit is a test pulse
        always_ff @(posedge I_CLK)
        begin
            if (!I_RSTN || restart)
                seen_reg <= 1'b0;
            else if (electronic && ((raw.a && !was_on_reg[0] && low_cnt_reg[0] != '0
                     && low_cnt_reg[0] < TPW'(TP_MAX)) || (raw.b && !was_on_reg[1]
                     && low_cnt_reg[1] != '0 && low_cnt_reg[1] < TPW'(TP_MAX))))
                seen_reg <= 1'b1;
        end

        // =================================================================
        // Cross-fault check for contact sets
        // =================================================================
        // An input reading high while its own supply pulse is low is fed elsewhere
        assign xf_now = !electronic && ((raw.a && !I_TP_OUT_A[p]) ||
                                        (raw.b && !I_TP_OUT_B[p]));

        always_ff @(posedge I_CLK)
        begin
            if (!I_RSTN || restart || electronic)
                xf_reg <= 1'b0;
            else if (xf_now)
                xf_reg <= 1'b1;
            else if (!raw.a && !raw.b)
                xf_reg <= 1'b0;
        end

        // =================================================================
        // Filters
        // =================================================================
        assign pair_on = filt;
        assign single_b_on = '{a: filt.b, b: 1'b0};

        pstf_stable_filter u_filt_a (
            .i_clk(I_CLK),
            .i_rstn(I_RSTN),
            .i_restart(restart),
            .i_tick(tick),
            .i_two_ch(two_ch),
            .i_timing(timing),
            .i_force_fault(xf_reg),
            .i_on(pair_on),
            .o_enable(en_a),
            .o_fault(flt_a)
        );

        pstf_stable_filter u_filt_b (
            .i_clk(I_CLK),
            .i_rstn(I_RSTN),
            .i_restart(restart || !is_dual),
            .i_tick(tick),
            .i_two_ch(1'b0),
            .i_timing(timing),
            .i_force_fault(xf_reg),
            .i_on(single_b_on),
            .o_enable(en_b),
            .o_fault(flt_b)
        );

        // =================================================================
        // Outputs
        // =================================================================
        always_ff @(posedge I_CLK)
        begin
            if (!I_RSTN)
            begin
                O_SAFE_ON[p] <= 1'b0;
                O_SAFE_ON_B[p] <= 1'b0;
                O_PORT_FAULT[p] <= 1'b0;
                O_CROSS_FAULT[p] <= 1'b0;
                O_TP_SEEN[p] <= 1'b0;
                O_XF_ACTIVE[p] <= 1'b0;
                O_TWO_WIRE[p] <= 1'b0;
            end
            else
            begin
                O_SAFE_ON[p] <= en_a && !restart;
                O_SAFE_ON_B[p] <= (two_ch ? en_a : en_b) && !restart;
                O_PORT_FAULT[p] <= flt_a || (is_dual && flt_b);
                O_CROSS_FAULT[p] <= xf_reg;
                O_TP_SEEN[p] <= seen_reg;
                O_XF_ACTIVE[p] <= !electronic;
                O_TWO_WIRE[p] <= (set_reg == pstf_pkg::PSET_OSSD_2W);
            end
        end
    end

endmodule : port_stable_time_filter

// ==== pstf_properties.sv ====
// Concurrent checks on the port filter outputs
`timescale 1ns/1ps
module pstf_properties #(
    parameter int NUM_PORTS = 8
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // Inputs seen
    input wire logic [NUM_PORTS-1:0][1:0] I_PORT_SET,
    input wire logic [NUM_PORTS-1:0] I_CH_A,
    input wire logic [NUM_PORTS-1:0] I_CH_B,
    input wire logic [NUM_PORTS-1:0] I_TP_OUT_A,
    input wire logic [NUM_PORTS-1:0] I_TP_OUT_B,
    // Outputs seen
    input wire logic [NUM_PORTS-1:0] O_SAFE_ON,
    input wire logic [NUM_PORTS-1:0] O_SAFE_ON_B,
    input wire logic [NUM_PORTS-1:0] O_PORT_FAULT,
    input wire logic [NUM_PORTS-1:0] O_CROSS_FAULT,
    input wire logic [NUM_PORTS-1:0] O_TP_SEEN,
    input wire logic [NUM_PORTS-1:0] O_XF_ACTIVE,
    input wire logic [NUM_PORTS-1:0] O_TWO_WIRE
);
    // =====================================================================
    // Helpers: decoding is trusted only once the set has been steady
    // =====================================================================
    logic [NUM_PORTS-1:0] xf_exp;
    logic [NUM_PORTS-1:0] two_exp;
    logic [NUM_PORTS-1:0] single;
    logic [NUM_PORTS-1:0] xf_hit;
    logic [NUM_PORTS-1:0] fall_e;
    logic [NUM_PORTS-1:0] drop_c;
    logic [NUM_PORTS-1:0] rise;
    logic [NUM_PORTS-1:0] ch_a_reg;
    logic [NUM_PORTS-1:0] safe_reg;
    logic [NUM_PORTS-1:0][1:0] set_reg;
    logic [1:0] age_reg;
    logic settled;
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            xf_exp[p] = I_PORT_SET[p][1];
            two_exp[p] = I_PORT_SET[p] == 2'h1;
            single[p] = I_PORT_SET[p] == 2'h3;
        end
    end
    assign settled = age_reg == 2'h3;
    assign xf_hit = (I_CH_A & ~I_TP_OUT_A) | (I_CH_B & ~I_TP_OUT_B);
    assign fall_e = ~xf_exp & ~I_CH_A & ch_a_reg & O_SAFE_ON;
    assign drop_c = xf_exp & ~I_CH_A & O_SAFE_ON;
    assign rise = O_SAFE_ON & ~safe_reg & ~single;
    always_ff @(posedge I_CLK)
    begin
        set_reg <= I_PORT_SET;
        ch_a_reg <= I_CH_A;
        safe_reg <= O_SAFE_ON;
    end
    always_ff @(posedge I_CLK)
    begin
        if (!I_RSTN || set_reg != I_PORT_SET)
            age_reg <= 2'h0;
        else if (!settled)
            age_reg <= age_reg + 2'h1;
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RSTN);
    // =====================================================================
    // Assertions
    // =====================================================================
    chk_xf_by_set: assert property (settled |-> O_XF_ACTIVE == xf_exp)
        else $error("cross-fault enable does not follow the set");
    chk_wire_by_set: assert property (settled |-> O_TWO_WIRE == two_exp)
        else $error("output wiring does not follow the set");
    chk_no_elec_xf: assert property (settled |-> (O_CROSS_FAULT & ~xf_exp) == '0)
        else $error("cross fault flagged on an electronic port");
    chk_xf_detect: assert property (settled && (xf_exp & xf_hit) != '0 |-> ##2
        (O_CROSS_FAULT & $past(xf_exp & xf_hit, 2)) == $past(xf_exp & xf_hit, 2))
        else $error("cross fault not flagged two cycles on");
    chk_xf_to_fault: assert property (settled && (O_CROSS_FAULT & ~safe_reg) != '0
        && (O_CROSS_FAULT & ~$past(O_CROSS_FAULT)) != '0
        |=> (O_PORT_FAULT & $past(O_CROSS_FAULT)) == $past(O_CROSS_FAULT))
        else $error("cross fault did not raise the port fault");
    chk_contact_drop: assert property (settled && drop_c != '0 |-> ##3
        (O_SAFE_ON & $past(drop_c, 3)) == '0)
        else $error("contact port stayed enabled after an input went off");
    chk_pulse_mask: assert property (settled && fall_e != '0 |-> ##2
        (O_SAFE_ON & $past(fall_e, 2)) == $past(fall_e, 2))
        else $error("short low on an electronic port was not masked");
    chk_on_or_fault: assert property (settled |-> (O_SAFE_ON & O_PORT_FAULT & ~single) == '0)
        else $error("pair enabled and faulted at once");
    chk_rise_both_on: assert property (settled && rise != '0 |->
        ($past(I_CH_A & I_CH_B) & rise) == rise)
        else $error("pair enabled without both inputs on");
    chk_b_copy: assert property (settled |-> ((O_SAFE_ON_B ^ O_SAFE_ON) & ~single) == '0)
        else $error("second result differs on a paired port");
endmodule : pstf_properties

bind port_stable_time_filter pstf_properties #(.NUM_PORTS(NUM_PORTS)) i_pstf_properties (
    .I_CLK(I_CLK),
    .I_RSTN(I_RSTN),
    .I_PORT_SET(I_PORT_SET),
    .I_CH_A(I_CH_A),
    .I_CH_B(I_CH_B),
    .I_TP_OUT_A(I_TP_OUT_A),
    .I_TP_OUT_B(I_TP_OUT_B),
    .O_SAFE_ON(O_SAFE_ON),
    .O_SAFE_ON_B(O_SAFE_ON_B),
    .O_PORT_FAULT(O_PORT_FAULT),
    .O_CROSS_FAULT(O_CROSS_FAULT),
    .O_TP_SEEN(O_TP_SEEN),
    .O_XF_ACTIVE(O_XF_ACTIVE),
    .O_TWO_WIRE(O_TWO_WIRE)
);

// ==== pstf_switchgear.sv ====
// Safety switchgear model feeding the port inputs
`timescale 1ns/1ps
module pstf_switchgear #(
    parameter int NUM_PORTS = 8
) (
    // Behaviour per port
    input wire logic [NUM_PORTS-1:0] i_elec,
    input wire logic [NUM_PORTS-1:0] i_close_a,
    input wire logic [NUM_PORTS-1:0] i_close_b,
    input wire logic [NUM_PORTS-1:0] i_pulse_a,
    input wire logic [NUM_PORTS-1:0] i_short_a,
    // Supply from the device
    input wire logic [NUM_PORTS-1:0] i_tp_a,
    input wire logic [NUM_PORTS-1:0] i_tp_b,
    // Switching outputs
    output logic [NUM_PORTS-1:0] o_ch_a,
    output logic [NUM_PORTS-1:0] o_ch_b
);
    // =====================================================================
    // Outputs
    // =====================================================================
    // OSSDs source their own supply and dip only for test pulses; a dry contact
    // passes the device supply, so an open contact reads low; a short feeds a closed contact A
    assign o_ch_a = (i_elec & i_close_a & ~i_pulse_a) | (~i_elec & i_close_a & (i_tp_a | i_short_a));
    assign o_ch_b = (i_elec & i_close_b) | (~i_elec & i_close_b & i_tp_b);
endmodule : pstf_switchgear

// ==== port_stable_time_filter_tb.sv ====
// Self-checking bench for the port filter, one port per parameter set
`timescale 1ns/1ps
module port_stable_time_filter_tb;
    // =====================================================================
    // Sizes and expected times
    // =====================================================================
    localparam int N = 4;
    localparam int DIV = 4;
    localparam int TPM = 8;
    localparam int SE = int'(pstf_pkg::STABLE_OSSD_TICKS) * DIV;
    localparam int SC = int'(pstf_pkg::STABLE_CONTACT_TICKS) * DIV;
    localparam int ME = int'(pstf_pkg::MONITOR_OSSD_TICKS) * DIV;
    localparam int MC = int'(pstf_pkg::MONITOR_CONTACT_TICKS) * DIV;
    logic clk;
    logic rstn;
    logic [N-1:0][1:0] port_set;
    logic [N-1:0] ch_a, ch_b, tp_a, tp_b, close_a, close_b, pulse_a, short_a, elec;
    logic [N-1:0] safe_on, safe_on_b, port_fault, cross_fault, tp_seen, xf_active, two_wire;
    int fails;
    int num_checks;
    assign elec = 4'b0011;
    port_stable_time_filter #(.NUM_PORTS(N), .TICK_DIV(DIV), .TP_MAX(TPM))
        i_port_stable_time_filter (
        .I_CLK(clk), .I_RSTN(rstn), .I_PORT_SET(port_set), .I_CH_A(ch_a), .I_CH_B(ch_b),
        .I_TP_OUT_A(tp_a), .I_TP_OUT_B(tp_b), .O_SAFE_ON(safe_on), .O_SAFE_ON_B(safe_on_b),
        .O_PORT_FAULT(port_fault), .O_CROSS_FAULT(cross_fault), .O_TP_SEEN(tp_seen),
        .O_XF_ACTIVE(xf_active), .O_TWO_WIRE(two_wire));
    pstf_switchgear #(.NUM_PORTS(N)) i_pstf_switchgear (
        .i_elec(elec), .i_close_a(close_a), .i_close_b(close_b), .i_pulse_a(pulse_a),
        .i_short_a(short_a), .i_tp_a(tp_a), .i_tp_b(tp_b), .o_ch_a(ch_a), .o_ch_b(ch_b));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t ns: seen %b expected %b", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_qualify();
        close_a = 4'hf;
        cyc(10);
        close_b = 4'hf;
        cyc(SE - 20);
        check(safe_on, 4'h0);
        cyc(30 + DIV);
        check(safe_on, 4'b0011);
        check(safe_on_b, 4'b0011);
        cyc(600);
        close_b[2] = 1'b0;
        cyc(1);
        close_b[2] = 1'b1;
        // Bounce restarts port 2, which would otherwise be on here
        cyc(SC - 995);
        check(safe_on, 4'b1011);
        check(safe_on_b, 4'b1011);
        cyc(1010);
        check(safe_on, 4'hf);
        check(port_fault, 4'h0);
    endtask : t_qualify
    task automatic t_drop();
        pulse_a[0] = 1'b1;
        close_a[1] = 1'b0;
        close_a[3] = 1'b0;
        cyc(4);
        pulse_a[0] = 1'b0;
        check(safe_on, 4'b0111);
        check(safe_on_b, 4'b1111);
        cyc(TPM + 8);
        check(safe_on, 4'b0101);
        check(tp_seen, 4'b0001);
        close_a = 4'h0;
        close_b = 4'h0;
        cyc(TPM + 6);
        check(safe_on | safe_on_b | port_fault, 4'h0);
    endtask : t_drop
    task automatic t_fault();
        close_a = 4'b1011;
        close_b[1] = 1'b1;
        cyc(20);
        close_b[1] = 1'b0;
        close_a[3] = 1'b0;
        cyc(ME - 40);
        check(port_fault, 4'h0);
        cyc(24 + 2 * DIV);
        check(port_fault, 4'b0011);
        cyc(MC - SC / 2 - ME - 4 - 2 * DIV);
        // Port 3 comes back too late to qualify inside its window
        close_a[3] = 1'b1;
        cyc(SC / 2 - 20);
        check(port_fault, 4'b0011);
        cyc(24 + 2 * DIV);
        check(port_fault, 4'b1011);
        check(safe_on, 4'h0);
        close_a = 4'h0;
        // Electronic ports see the off level only after the test pulse mask runs out
        cyc(TPM + 6);
        check(port_fault, 4'h0);
    endtask : t_fault
    task automatic t_cross();
        tp_a = 4'b1010;
        short_a = 4'b0101;
        close_a = 4'b0101;
        cyc(5);
        check(cross_fault, 4'b0100);
        check(port_fault, 4'b0100);
        tp_a = 4'hf;
        short_a = 4'h0;
        close_a = 4'h0;
        cyc(6);
        check(cross_fault | port_fault, 4'h0);
    endtask : t_cross
    // =====================================================================
    // Main sequence and watchdog
    // =====================================================================
    initial
    begin
        fails = 0;
        num_checks = 0;
        rstn = 1'b0;
        port_set = {2'h3, 2'h2, 2'h1, 2'h0};
        tp_a = 4'hf;
        tp_b = 4'hf;
        close_a = 4'h0;
        close_b = 4'h0;
        pulse_a = 4'h0;
        short_a = 4'h0;
        cyc(2);
        check(safe_on | port_fault | xf_active, 4'h0);
        rstn = 1'b1;
        cyc(4);
        check(xf_active, 4'b1100);
        check(two_wire, 4'b0010);
        t_qualify();
        t_drop();
        t_fault();
        t_cross();
        final_report();
    end
    initial
    begin
        #((MC + ME + 3 * SC) * 4);
        fails++;
        final_report();
    end
endmodule : port_stable_time_filter_tb
